// *** spicc_pkg.sv ***
package spicc_pkg;

	// Register byte addresses on the APB word grid.
	localparam logic [7:0] SPICC_ADDR_CTRL1 = 8'h00;
	localparam logic [7:0] SPICC_ADDR_CTRL2 = 8'h04;
	localparam logic [7:0] SPICC_ADDR_BAUD = 8'h08;
	localparam logic [7:0] SPICC_ADDR_STAT = 8'h0C;
	localparam logic [7:0] SPICC_ADDR_DATA = 8'h10;

	// Reset values.
	localparam logic [7:0] SPICC_CTRL1_RST = 8'h00;
	localparam logic [3:0] SPICC_CTRL2_RST = 4'h0;
	localparam logic [7:0] SPICC_BAUD_RST = 8'h00;
	localparam logic [7:0] SPICC_DATA_RST = 8'h00;

	// Control register 2 field positions.
	localparam int SPICC_C2_MODE_FAULT_EN = 4;
	localparam int SPICC_C2_SW_OE = 3;
	localparam int SPICC_C2_STOP_IN_WAIT = 1;
	localparam int SPICC_C2_SW_MODE = 0;

	// Status register field positions.
	localparam int SPICC_ST_RX_FULL = 7;
	localparam int SPICC_ST_TX_EMPTY = 5;
	localparam int SPICC_ST_MODE_FAULT = 4;

	// Baud register fields: prescale in 6:4, rate in 2:0.
	localparam int SPICC_BAUD_PRE_LSB = 4;
	localparam int SPICC_BAUD_RATE_LSB = 0;

	// Index of the last of the 16 serial clock edges in one byte.
	localparam logic [3:0] SPICC_LAST_EDGE = 4'hF;

	// Number of synchronised pins.
	localparam int SPICC_PINS = 4;

	typedef struct packed {
		logic rxFaultIrqEnable;
		logic portEnable;
		logic txEmptyIrqEnable;
		logic masterSelect;
		logic clockPolarity;
		logic clockPhase;
		logic selectOutputEnable;
		logic lsbFirst;
	} spicc_ctrl1_t;

	typedef struct packed {
		logic modeFaultEnable;
		logic singleWireOutputEnable;
		logic stopInWait;
		logic singleWireMode;
	} spicc_ctrl2_t;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic ss;
	} spicc_pins_t;

endpackage : spicc_pkg

// *** spicc_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module spicc_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Asynchronous levels in, synchronised levels out.
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] firstStage;

	// Two flip-flops per bit; only the second reads the first.
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				firstStage[i] <= 1'b0;
				syncOut[i] <= 1'b0;
			end else begin
				firstStage[i] <= asyncIn[i];
				syncOut[i] <= firstStage[i];
			end
		end
	end

endmodule : spicc_sync

`default_nettype wire

// *** spicc_control.sv ***
// Summary of operation
// - Every stop mode forces the port inactive; deep stop restores reset state.
// - Light stop halts the port's clocks and keeps all register contents.
// - Light stop exit by reset resets the port; by interrupt it resumes.
// - Five 8-bit registers: two controls, baud, status and data.
// - Control 1 bit 7 requests an interrupt on receive-full or mode fault.
// - Clearing enable aborts transfer, empties buffers, clears rx-full, sets tx-empty.
// - Control 1 bit 5 requests an interrupt while transmit-empty is set.
// - Control 1 bit 4 selects slave (0) or clock-driving master (1).
// - Bit 3 inverts the serial clock; 0 idles low, 1 idles high.
// - Bit 2 places the first clock edge mid-bit (0) or at bit start (1).
// - Bit 0 selects MSB first (0) or LSB first (1) shifting.
// - In slave mode the select pin is always the active-low select input.
// - Control 2 bits 7, 6, 5 and 2 read back as zero.
// - In single-wire mode control 2 bit 3 enables the shared data driver.
// - Control 2 bit 1 stops the port's clocks during wait.
// - Control 2 bit 0 selects single-wire data on the role's shared pin.
// - While disabled, all four pins return to general-purpose I/O.
// - Without single-wire mode, MOSI is master output and slave input.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module spicc_control (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_n,
	// Power mode controls.
	input wire logic stopDeep,
	input wire logic stopLight,
	input wire logic waitMode,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial pins.
	input wire spicc_pkg::spicc_pins_t pinIn,
	output spicc_pkg::spicc_pins_t pinOut,
	output spicc_pkg::spicc_pins_t pinOe,
	output spicc_pkg::spicc_pins_t pinOwn,
	// Interrupt request.
	output logic irq
);

	spicc_pkg::spicc_ctrl1_t ctrl1Reg;
	spicc_pkg::spicc_ctrl2_t ctrl2Reg;
	spicc_pkg::spicc_pins_t pinSync;
	logic [7:0] baudReg;
	logic [7:0] txBufReg;
	logic [7:0] rxBufReg;
	logic [7:0] shiftReg;
	logic [7:0] shiftNext;
	logic [7:0] readData;
	logic [10:0] divCnt;
	logic [10:0] halfCount;
	logic [3:0] edgeIdx;
	logic rxFull;
	logic txEmpty;
	logic modeFault;
	logic armRx;
	logic armTx;
	logic armFault;
	logic busy;
	logic sckLevel;
	logic sckPrev;
	logic rxBit;
	logic hold;
	logic enabled;
	logic isMaster;
	logic ssAutoOut;
	logic ssFaultIn;
	logic dataIn;
	logic dataOut;
	logic edgeEv;
	logic sampleEv;
	logic shiftEv;
	logic doneEv;
	logic startEv;
	logic faultEv;
	logic slaveSel;
	logic wrAcc;
	logic rdAcc;
	logic mapped;

	spicc_sync #(
		.WIDTH(spicc_pkg::SPICC_PINS)
	) u_sync (
		.clk(core_clk),
		.rst_n(rst_n),
		.asyncIn(pinIn),
		.syncOut(pinSync)
	);

	assign enabled = ctrl1Reg.portEnable && !stopLight && !stopDeep;
	assign hold = stopLight || (waitMode && ctrl2Reg.stopInWait);
	assign isMaster = ctrl1Reg.masterSelect;
	assign ssAutoOut = isMaster && ctrl2Reg.modeFaultEnable &&
		ctrl1Reg.selectOutputEnable;
	assign ssFaultIn = isMaster && ctrl2Reg.modeFaultEnable &&
		!ctrl1Reg.selectOutputEnable;
	assign slaveSel = !isMaster && !pinSync.ss;

	always_comb begin
		if (ctrl2Reg.singleWireMode) begin
			dataIn = isMaster ? pinSync.mosi : pinSync.miso;
		end else begin
			dataIn = isMaster ? pinSync.miso : pinSync.mosi;
		end
	end

	assign dataOut = ctrl1Reg.lsbFirst ? shiftReg[0] : shiftReg[7];
	always_comb begin
		if (ctrl1Reg.lsbFirst) begin
			shiftNext = {(sampleEv && doneEv) ? dataIn : rxBit,
				shiftReg[7:1]};
		end else begin
			shiftNext = {shiftReg[6:0],
				(sampleEv && doneEv) ? dataIn : rxBit};
		end
	end

	assign halfCount = 11'(({8'h00, baudReg[spicc_pkg::SPICC_BAUD_PRE_LSB +: 3]}
		+ 11'h001) << baudReg[spicc_pkg::SPICC_BAUD_RATE_LSB +: 3]) - 11'h001;

	always_comb begin
		if (isMaster) begin
			edgeEv = busy && !hold && (divCnt == halfCount);
		end else begin
			edgeEv = busy && !hold && (pinSync.sck != sckPrev);
		end
	end
	assign sampleEv = edgeEv && (edgeIdx[0] == ctrl1Reg.clockPhase);
	assign shiftEv = edgeEv && !sampleEv &&
		!(ctrl1Reg.clockPhase && (edgeIdx == 4'h0));
	assign doneEv = edgeEv && (edgeIdx == spicc_pkg::SPICC_LAST_EDGE);
	assign startEv = enabled && !busy && !hold &&
		(isMaster ? !txEmpty : slaveSel);
	assign faultEv = enabled && ssFaultIn && !pinSync.ss && !hold;

	assign wrAcc = psel && penable && pready && pwrite;
	assign rdAcc = psel && penable && pready && !pwrite;
	assign mapped = (paddr == spicc_pkg::SPICC_ADDR_CTRL1) ||
		(paddr == spicc_pkg::SPICC_ADDR_CTRL2) ||
		(paddr == spicc_pkg::SPICC_ADDR_BAUD) ||
		(paddr == spicc_pkg::SPICC_ADDR_STAT) ||
		(paddr == spicc_pkg::SPICC_ADDR_DATA);

	always_comb begin
		readData = 8'h00;
		case (paddr)
			spicc_pkg::SPICC_ADDR_CTRL1: readData = ctrl1Reg;
			spicc_pkg::SPICC_ADDR_CTRL2: begin
				readData[spicc_pkg::SPICC_C2_MODE_FAULT_EN] =
					ctrl2Reg.modeFaultEnable;
				readData[spicc_pkg::SPICC_C2_SW_OE] =
					ctrl2Reg.singleWireOutputEnable;
				readData[spicc_pkg::SPICC_C2_STOP_IN_WAIT] =
					ctrl2Reg.stopInWait;
				readData[spicc_pkg::SPICC_C2_SW_MODE] =
					ctrl2Reg.singleWireMode;
			end
			spicc_pkg::SPICC_ADDR_BAUD: readData = baudReg;
			spicc_pkg::SPICC_ADDR_STAT: begin
				readData[spicc_pkg::SPICC_ST_RX_FULL] = rxFull;
				readData[spicc_pkg::SPICC_ST_TX_EMPTY] = txEmpty;
				readData[spicc_pkg::SPICC_ST_MODE_FAULT] = modeFault;
			end
			spicc_pkg::SPICC_ADDR_DATA: readData = rxBufReg;
			default: readData = 8'h00;
		endcase
	end

	// APB answer, one access cycle with no wait states.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= {24'h00_0000, readData};
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1Reg <= spicc_pkg::SPICC_CTRL1_RST;
			ctrl2Reg <= spicc_pkg::SPICC_CTRL2_RST;
			baudReg <= spicc_pkg::SPICC_BAUD_RST;
		end else if (stopDeep) begin
			ctrl1Reg <= spicc_pkg::SPICC_CTRL1_RST;
			ctrl2Reg <= spicc_pkg::SPICC_CTRL2_RST;
			baudReg <= spicc_pkg::SPICC_BAUD_RST;
		end else if (wrAcc) begin
			if (paddr == spicc_pkg::SPICC_ADDR_CTRL1) begin
				ctrl1Reg <= pwdata[7:0];
			end
			if (paddr == spicc_pkg::SPICC_ADDR_CTRL2) begin
				ctrl2Reg <= {pwdata[spicc_pkg::SPICC_C2_MODE_FAULT_EN],
					pwdata[spicc_pkg::SPICC_C2_SW_OE],
					pwdata[spicc_pkg::SPICC_C2_STOP_IN_WAIT],
					pwdata[spicc_pkg::SPICC_C2_SW_MODE]};
			end
			if (paddr == spicc_pkg::SPICC_ADDR_BAUD) begin
				baudReg <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
			end
		end
	end

	// Status flags and their read-then-access clear sequences.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxFull <= 1'b0;
			txEmpty <= 1'b1;
			modeFault <= 1'b0;
			armRx <= 1'b0;
			armTx <= 1'b0;
			armFault <= 1'b0;
			txBufReg <= spicc_pkg::SPICC_DATA_RST;
			rxBufReg <= spicc_pkg::SPICC_DATA_RST;
		end else if (stopDeep || !ctrl1Reg.portEnable) begin
			rxFull <= 1'b0;
			txEmpty <= 1'b1;
			modeFault <= 1'b0;
			armRx <= 1'b0;
			armTx <= 1'b0;
			armFault <= 1'b0;
			txBufReg <= spicc_pkg::SPICC_DATA_RST;
			rxBufReg <= spicc_pkg::SPICC_DATA_RST;
		end else begin
			if (rdAcc && paddr == spicc_pkg::SPICC_ADDR_STAT) begin
				armRx <= rxFull;
				armTx <= txEmpty;
				armFault <= modeFault;
			end
			if (rdAcc && paddr == spicc_pkg::SPICC_ADDR_DATA && armRx) begin
				rxFull <= 1'b0;
				armRx <= 1'b0;
			end
			if (wrAcc && paddr == spicc_pkg::SPICC_ADDR_DATA && armTx
				&& txEmpty) begin
				txBufReg <= pwdata[7:0];
				txEmpty <= 1'b0;
				armTx <= 1'b0;
			end
			if (wrAcc && paddr == spicc_pkg::SPICC_ADDR_CTRL1 && armFault) begin
				modeFault <= 1'b0;
				armFault <= 1'b0;
			end
			// Hardware set wins over a clear in the same cycle.
			if (doneEv) begin
				rxBufReg <= shiftNext;
				rxFull <= 1'b1;
			end
			if (startEv && isMaster) begin
				txEmpty <= 1'b1;
			end
			if (startEv && !isMaster && !txEmpty) begin
				txEmpty <= 1'b1;
			end
			if (faultEv) begin
				modeFault <= 1'b1;
			end
		end
	end

	// Transfer engine: divider, edge counter and shifter.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			divCnt <= 11'h000;
			edgeIdx <= 4'h0;
			sckLevel <= 1'b0;
			sckPrev <= 1'b0;
			rxBit <= 1'b0;
			shiftReg <= spicc_pkg::SPICC_DATA_RST;
		end else if (stopDeep || !ctrl1Reg.portEnable || faultEv) begin
			busy <= 1'b0;
			divCnt <= 11'h000;
			edgeIdx <= 4'h0;
			sckLevel <= 1'b0;
			sckPrev <= pinSync.sck;
			rxBit <= 1'b0;
		end else if (!hold) begin
			sckPrev <= pinSync.sck;
			if (startEv) begin
				busy <= 1'b1;
				divCnt <= 11'h000;
				edgeIdx <= 4'h0;
				sckLevel <= 1'b0;
				if (!txEmpty) begin
					shiftReg <= txBufReg;
				end
			end else if (busy && !isMaster && !slaveSel) begin
				busy <= 1'b0;
				edgeIdx <= 4'h0;
			end else if (busy) begin
				divCnt <= (divCnt == halfCount) ? 11'h000 : divCnt + 11'h001;
				if (edgeEv) begin
					edgeIdx <= edgeIdx + 4'h1;
					sckLevel <= isMaster ? !sckLevel : 1'b0;
				end
				if (sampleEv) begin
					rxBit <= dataIn;
				end
				if (shiftEv || (sampleEv && doneEv)) begin
					shiftReg <= shiftNext;
				end
				if (doneEv) begin
					busy <= 1'b0;
				end
			end
		end
	end

	// Registered pin drivers, ownership and interrupt request.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinOut <= '0;
			pinOe <= '0;
			pinOwn <= '0;
			irq <= 1'b0;
		end else begin
			irq <= ctrl1Reg.portEnable &&
				((ctrl1Reg.rxFaultIrqEnable && (rxFull || modeFault)) ||
				(ctrl1Reg.txEmptyIrqEnable && txEmpty));
			if (!enabled) begin
				pinOut <= '0;
				pinOe <= '0;
				pinOwn <= '0;
			end else begin
				pinOut.sck <= ctrl1Reg.clockPolarity ^ sckLevel;
				pinOe.sck <= isMaster;
				pinOwn.sck <= 1'b1;
				pinOut.mosi <= dataOut;
				pinOut.miso <= dataOut;
				if (ctrl2Reg.singleWireMode) begin
					pinOe.mosi <= isMaster &&
						ctrl2Reg.singleWireOutputEnable;
					pinOe.miso <= !isMaster && slaveSel &&
						ctrl2Reg.singleWireOutputEnable;
					pinOwn.mosi <= isMaster;
					pinOwn.miso <= !isMaster;
				end else begin
					pinOe.mosi <= isMaster;
					pinOe.miso <= slaveSel;
					pinOwn.mosi <= 1'b1;
					pinOwn.miso <= 1'b1;
				end
				pinOut.ss <= !busy;
				pinOe.ss <= ssAutoOut;
				pinOwn.ss <= !isMaster || ctrl2Reg.modeFaultEnable;
			end
		end
	end

endmodule : spicc_control

`default_nettype wire

// *** spicc_control_properties.sv ***
`timescale 1ns/10ps
`default_nettype none

module spicc_control_properties (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_n,
	// Power mode controls.
	input wire logic stopDeep,
	input wire logic stopLight,
	input wire logic waitMode,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Serial pins.
	input wire spicc_pkg::spicc_pins_t pinIn,
	input wire spicc_pkg::spicc_pins_t pinOut,
	input wire spicc_pkg::spicc_pins_t pinOe,
	input wire spicc_pkg::spicc_pins_t pinOwn,
	// Interrupt request.
	input wire logic irq
);
	logic [7:0] c1Reg;
	logic [7:0] c2Reg;
	logic done, run, mst, slv, irqCan, mapOk;
	assign done = psel && penable && pready && pwrite;
	assign run = !stopLight && !stopDeep && c1Reg[6];
	assign mst = run && c1Reg[4];
	assign slv = run && !c1Reg[4];
	assign irqCan = c1Reg[6] && (c1Reg[7] || c1Reg[5]);
	assign mapOk = paddr <= 8'h10 && paddr[1:0] == 2'h0;
	// Shadow copy of the two control registers.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			c1Reg <= 8'h00;
			c2Reg <= 8'h00;
		end else if (stopDeep) begin
			c1Reg <= 8'h00;
			c2Reg <= 8'h00;
		end else if (done && paddr == spicc_pkg::SPICC_ADDR_CTRL1) begin
			c1Reg <= pwdata[7:0];
		end else if (done && paddr == spicc_pkg::SPICC_ADDR_CTRL2) begin
			c2Reg <= pwdata[7:0];
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_err_map: assert property (pready |-> pslverr == !mapOk)
		else $error("pslverr wrong for address");
	a_ctrl2_zero: assert property (pready && !pwrite &&
		paddr == spicc_pkg::SPICC_ADDR_CTRL2 |-> prdata[31:5] == 27'h0 &&
		!prdata[2]) else $error("ctrl2 reserved bit set");
	a_off_release: assert property (!c1Reg[6] [*3] |-> pinOwn == 4'h0)
		else $error("pins kept while disabled");
	a_stop_release: assert property (stopLight [*3] |-> pinOwn == 4'h0)
		else $error("pins kept in stop");
	a_irq_cause: assert property (irq |-> $past(irqCan) ||
		$past(irqCan, 2)) else $error("irq without enable");
	a_slave_pins: assert property (slv [*3] |-> !pinOe.ss &&
		pinOwn.ss && !pinOe.sck) else $error("slave pins wrong");
	a_master_pins: assert property ((mst && !c2Reg[0]) [*3] |->
		pinOe.mosi && !pinOe.miso && pinOe.sck)
		else $error("master pins wrong");
	a_ss_gpio: assert property ((mst && !c2Reg[4]) [*3] |->
		!pinOwn.ss) else $error("ss taken without fault enable");
	a_wire_oe: assert property ((mst && c2Reg[0]) [*3] |->
		pinOe.mosi == $past(c2Reg[3]) && !pinOwn.miso)
		else $error("single wire driver wrong");
	c_slverr: cover property (pready && pslverr);
	c_irq: cover property ($rose(irq));
	c_wire: cover property (mst && c2Reg[0]);
endmodule : spicc_control_properties

bind spicc_control spicc_control_properties u_spicc_control_properties (
	.core_clk(core_clk), .rst_n(rst_n), .stopDeep(stopDeep),
	.stopLight(stopLight), .waitMode(waitMode), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
	.pinOut(pinOut), .pinOe(pinOe), .pinOwn(pinOwn), .irq(irq));

`default_nettype wire

// *** spicc_peer.sv ***
`timescale 1ns/10ps
`default_nettype none

module spicc_peer (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_n,
	// Block side pins.
	input wire spicc_pkg::spicc_pins_t pinOut,
	input wire spicc_pkg::spicc_pins_t pinOe,
	output spicc_pkg::spicc_pins_t pinIn
);
	logic sckM = 1'b0;
	logic mosiM = 1'b0;
	logic ssM = 1'b1;
	logic tog;
	spicc_pkg::spicc_pins_t far;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tog <= 1'b0;
		end else begin
			tog <= ~tog;
		end
	end
	// echo the master output as our reply.
	always_comb begin
		far.sck = sckM;
		far.mosi = ssM ? tog : mosiM;
		far.miso = pinOe.mosi ? pinOut.mosi : tog;
		far.ss = ssM;
	end
	assign pinIn = (pinOut & pinOe) | (far & ~pinOe);
	task automatic drive(input logic v);
		#5 ssM = v;
	endtask : drive
	// mode 0 frame, most significant bit first.
	task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
		#5 ssM = 1'b0;
		#200;
		for (int i = 7; i >= 0; i--) begin
			mosiM = tx[i];
			#100 sckM = 1'b1;
			rx[i] = pinIn.miso;
			#100 sckM = 1'b0;
		end
		#100 ssM = 1'b1;
	endtask : frame
endmodule : spicc_peer

`default_nettype wire

// *** tb_spicc_control.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; \
	if ((g) !== (e)) begin n_fail++; \
	$display("FAIL %s exp %0h got %0h", nm, e, g); end end

module tb_spicc_control;
	localparam logic [7:0] C1 = spicc_pkg::SPICC_ADDR_CTRL1;
	localparam logic [7:0] C2 = spicc_pkg::SPICC_ADDR_CTRL2;
	localparam logic [7:0] ST = spicc_pkg::SPICC_ADDR_STAT;
	localparam logic [7:0] DT = spicc_pkg::SPICC_ADDR_DATA;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic stopDeep = 1'b0;
	logic stopLight = 1'b0;
	logic waitMode = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, irq, err;
	logic [7:0] pb;
	spicc_pkg::spicc_pins_t pinIn, pinOut, pinOe, pinOwn;
	int n_fail = 0;
	int n_tests = 0;
	spicc_control u_spicc_control (.core_clk(core_clk), .rst_n(rst_n),
		.stopDeep(stopDeep), .stopLight(stopLight), .waitMode(waitMode),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.pinOwn(pinOwn), .irq(irq));
	spicc_peer u_spicc_peer (.core_clk(core_clk), .rst_n(rst_n),
		.pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude
	task automatic lost(input logic bad);
		if (bad) begin
			n_fail++;
			conclude();
		end
	endtask : lost
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		int n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		lost(n >= 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic waitRx();
		int n = 0;
		do begin
			apb(1'b0, ST, 8'h00);
			n++;
		end while (rd[spicc_pkg::SPICC_ST_RX_FULL] !== 1'b1 && n < 200);
		lost(n >= 200);
	endtask : waitRx
	task automatic tReset();
		apb(1'b0, C1, 8'h00);
		`CHK("ctrl1 reset", 32'h0, rd)
		apb(1'b0, C2, 8'h00);
		`CHK("ctrl2 reset", 32'h0, rd)
		`CHK("pins owned", 4'h0, pinOwn)
		apb(1'b0, 8'h14, 8'h00);
		`CHK("unmapped", 1'b1, err)
	endtask : tReset
	task automatic tRegs();
		apb(1'b1, C2, 8'hFF);
		apb(1'b0, C2, 8'h00);
		`CHK("ctrl2 reserved", 32'h1B, rd)
		apb(1'b1, C2, 8'h00);
		apb(1'b1, C1, 8'hAD);
		apb(1'b0, C1, 8'h00);
		`CHK("ctrl1 readback", 32'hAD, rd)
		apb(1'b1, spicc_pkg::SPICC_ADDR_BAUD, 8'h22);
	endtask : tRegs
	task automatic tMaster(input logic lsb, input logic pha);
		int n = 0;
		apb(1'b1, C1, 8'h58);
		cyc(3);
		`CHK("idle high", 1'b1, pinOut.sck)
		apb(1'b1, C1, {5'h1A, pha, 1'b0, lsb});
		cyc(3);
		`CHK("idle low", 2'b10, {pinOe.sck, pinOut.sck})
		`CHK("data oe", 2'b10, {pinOe.mosi, pinOe.miso})
		`CHK("ss gpio", 1'b0, pinOwn.ss)
		apb(1'b0, ST, 8'h00);
		apb(1'b1, DT, 8'h80);
		while (pinOut.sck === 1'b0 && n < 100) begin
			@(posedge core_clk);
			n++;
		end
		lost(n >= 100);
		`CHK("first bit", ~lsb, pinOut.mosi)
		waitRx();
		cyc(2);
		`CHK("rx irq", 1'b1, irq)
		apb(1'b0, DT, 8'h00);
		`CHK("rx data", 32'h80, rd)
		cyc(2);
		`CHK("rx irq clear", 1'b0, irq)
	endtask : tMaster
	task automatic tIrqOff();
		apb(1'b1, C1, 8'h70);
		cyc(3);
		`CHK("tx irq", 1'b1, irq)
		apb(1'b1, C1, 8'h50);
		cyc(3);
		`CHK("tx irq off", 1'b0, irq)
		apb(1'b0, ST, 8'h00);
		apb(1'b1, DT, 8'h5A);
		waitRx();
		apb(1'b1, DT, 8'hA5);
		cyc(4);
		apb(1'b1, C1, 8'h10);
		apb(1'b0, ST, 8'h00);
		`CHK("status off", 32'h20, rd)
		`CHK("pins off", 4'h0, pinOwn)
	endtask : tIrqOff
	task automatic tWire();
		apb(1'b1, C2, 8'h01);
		apb(1'b1, C1, 8'h50);
		cyc(3);
		`CHK("wire in", 2'b00, {pinOe.mosi, pinOwn.miso})
		apb(1'b1, C2, 8'h09);
		cyc(3);
		`CHK("wire out", 1'b1, pinOe.mosi)
		apb(1'b1, C2, 8'h10);
		u_spicc_peer.drive(1'b0);
		cyc(6);
		apb(1'b0, ST, 8'h00);
		`CHK("fault", 1'b1, rd[spicc_pkg::SPICC_ST_MODE_FAULT])
		u_spicc_peer.drive(1'b1);
		apb(1'b1, C1, 8'h52);
		cyc(3);
		`CHK("ss out", 2'b11, {pinOe.ss, pinOwn.ss})
	endtask : tWire
	task automatic tSlave();
		apb(1'b1, C1, 8'h42);
		cyc(3);
		`CHK("slave ss", 2'b01, {pinOe.ss, pinOwn.ss})
		apb(1'b0, ST, 8'h00);
		apb(1'b1, DT, 8'h3C);
		u_spicc_peer.frame(8'hC3, pb);
		`CHK("slave tx", 8'h3C, pb)
		waitRx();
		apb(1'b0, DT, 8'h00);
		`CHK("slave rx", 32'hC3, rd)
	endtask : tSlave
	task automatic tWait();
		apb(1'b1, C2, 8'h02);
		apb(1'b1, C1, 8'h50);
		apb(1'b0, ST, 8'h00);
		waitMode <= 1'b1;
		apb(1'b1, DT, 8'h11);
		cyc(250);
		apb(1'b0, ST, 8'h00);
		`CHK("wait frozen", 1'b0, rd[spicc_pkg::SPICC_ST_RX_FULL])
		apb(1'b1, C2, 8'h00);
		waitRx();
		waitMode <= 1'b0;
		apb(1'b0, DT, 8'h00);
		`CHK("wait runs", 32'h11, rd)
	endtask : tWait
	task automatic tStop();
		apb(1'b1, C1, 8'h50);
		apb(1'b0, ST, 8'h00);
		apb(1'b1, DT, 8'h77);
		cyc(20);
		stopLight <= 1'b1;
		cyc(4);
		`CHK("stop pins", 4'h0, pinOwn)
		apb(1'b0, C1, 8'h00);
		`CHK("stop keeps", 32'h50, rd)
		stopLight <= 1'b0;
		cyc(4);
		`CHK("resume", 1'b1, pinOwn.sck)
		waitRx();
		apb(1'b0, DT, 8'h00);
		`CHK("resume data", 32'h77, rd)
		stopLight <= 1'b1;
		rst_n <= 1'b0;
		cyc(2);
		rst_n <= 1'b1;
		stopLight <= 1'b0;
		apb(1'b0, C1, 8'h00);
		`CHK("stop reset", 32'h0, rd)
		apb(1'b1, C1, 8'h50);
		stopDeep <= 1'b1;
		cyc(2);
		stopDeep <= 1'b0;
		apb(1'b0, C1, 8'h00);
		`CHK("deep reset", 32'h0, rd)
	endtask : tStop
	initial begin
		cyc(2);
		rst_n <= 1'b1;
		tReset();
		tRegs();
		tMaster(1'b0, 1'b0);
		tMaster(1'b1, 1'b1);
		tIrqOff();
		tWire();
		tSlave();
		tWait();
		tStop();
		conclude();
	end
endmodule : tb_spicc_control

`default_nettype wire
